// file: dap_access_seq.sv
// Debug port access sequencer: host requests, retries, capture and pins
// Notes on behaviour
// - Reads with posted results issue the extra access and return fresh data.
// - On JTAG, load the access-port select instruction before access-port accesses.
// - On JTAG, load the debug-port select instruction before debug-port accesses; the RDBUFF read after an access-port read uses the access-port one.
// - Port selector 0 means debug-port register, 1 means access-port register.
// - Reissue on each WAIT until accepted or the limit is reached, then error.
// - Successful read reports its repetition count; failed read reports negative.
// - Successful write reports retries; unsupported combination reports -2.
// - Chain position 0 is the device nearest the data output pin.
// - Identification read returns the code, or zero when no device answers.
// - Extract a 32-bit word from the capture buffer at a given bit.
// - Keep a free-running millisecond uptime counter.
// - In serial wire mode keep the overrun detect enable bit cleared.
// - JTAG padding uses instruction bit totals and device counts around target.
`timescale 1ns/1ns
`default_nettype none
module dap_access_seq #(
    parameter int          MAX_WAIT   = dap_seq_pkg::WAIT_LIMIT,
    parameter int          MS_CYC     = dap_seq_pkg::MS_CYCLES,
    parameter logic [7:0]  PIN_AVAIL  = 8'hFF
) (
    // Clocks and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     link_clk,
    // Configuration
    input  wire logic                     jtag_mode,
    input  wire logic                     target_ok,
    input  wire dap_seq_pkg::chain_cfg_t  chain_cfg,
    // Host request and answer
    input  wire logic                     host_req_valid,
    input  wire dap_seq_pkg::host_req_t   host_req,
    output logic                          host_ready,
    output logic                          resp_valid,
    output var dap_seq_pkg::resp_t        resp,
    // Uptime and probe pins
    output logic [31:0]                   uptime_ms,
    input  wire logic [7:0]               probe_pins,
    // Link to the target
    output logic                          link_req_valid,
    output var dap_seq_pkg::link_req_t    link_req,
    input  wire logic                     link_rsp_valid,
    input  wire dap_seq_pkg::link_rsp_t   link_rsp
);
    import dap_seq_pkg::*;

    state_t                state_q, state_d;
    host_req_t             cmd_q, cmd_d;
    chain_cfg_t            cfg_q, cfg_d;
    logic                  jtag_q, jtag_d;
    logic [7:0]            retry_q, retry_d;
    logic                  pend_q, pend_d;
    logic                  req_tgl_q, req_tgl_d;
    link_req_t             word_q, word_d;
    resp_t                 res_q, res_d;
    logic [CAP_BITS-1:0]   cap_q, cap_d;
    logic                  ir_done_q, ir_done_d;
    logic                  ready_q, ready_d;
    logic                  rvalid_q, rvalid_d;
    resp_t                 resp_q, resp_d;
    logic                  ack_s1_q, ack_s2_q, ack_s3_q;
    logic                  ack_evt;
    logic                  ack_tgl;
    link_rsp_t             rsp_word;
    logic [7:0]            pin_s1_q, pin_s2_q;
    logic [31:0]           ms_cnt_q, ms_cnt_d;
    logic [31:0]           up_q, up_d;

    ////////////////////////////////////////////////////////////////////////////
    // Word extraction from the capture buffer
    function automatic logic [31:0] get_word(input logic [CAP_BITS-1:0] cap,
                                             input logic [7:0] off);
        logic [CAP_BITS+31:0] ext;
        ext = {32'h0, cap} >> off;   // Bits past the end read as zero
        return ext[31:0];
    endfunction

    // Build the link word for the current state
    function automatic link_req_t build_word(input state_t st, input host_req_t c,
                                             input logic jt, input chain_cfg_t cf);
        link_req_t w;
        w = '0;
        w.cfg            = cf;
        w.chain_position = c.chain_position;
        w.port_selector  = c.port_selector;
        w.register_index = c.register_index;
        w.rnw            = (c.op != OP_WRITE);
        w.wdata          = c.wdata;
        if (st == S_IR) begin
            w.kind  = LK_IR;
            w.wdata = {28'h0, c.port_selector ? IR_AP_SEL : IR_DP_SEL};
        end else if (st == S_POST) begin
            w.kind           = LK_POST;      // Collect the posted value
            w.rnw            = 1'b1;
            w.port_selector  = 1'b0;
            w.register_index = RDBUFF_IDX;
        end else if (c.op == OP_IDCODE) begin
            w.kind = LK_IDSCAN;
        end else begin
            w.kind = LK_ACCESS;
            if (!jt && !c.port_selector && c.op == OP_WRITE
                && c.register_index == CTRLSTAT_IDX) begin
                w.wdata[ORUN_BIT] = 1'b0;
            end
        end
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Answer toggle synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_tgl;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
        end
    end

    assign ack_evt = ack_s2_q ^ ack_s3_q;

    // Probe pin synchronisers
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    pin_s1_q[gi] <= 1'b0;
                    pin_s2_q[gi] <= 1'b0;
                end else begin
                    pin_s1_q[gi] <= probe_pins[gi];
                    pin_s2_q[gi] <= pin_s1_q[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb begin
        state_d   = state_q;
        cmd_d     = cmd_q;
        cfg_d     = cfg_q;
        jtag_d    = jtag_q;
        retry_d   = retry_q;
        pend_d    = pend_q;
        req_tgl_d = req_tgl_q;
        word_d    = word_q;
        res_d     = res_q;
        cap_d     = cap_q;
        ir_done_d = ir_done_q;
        case (state_q)
            S_IDLE: begin
                if (host_req_valid && ready_q) begin
                    cmd_d     = host_req;
                    cfg_d     = chain_cfg;
                    jtag_d    = jtag_mode;
                    retry_d   = 8'h00;
                    ir_done_d = 1'b0;
                    res_d     = '{status: STAT_ERR, data: ERR_DATA};
                    case (host_req.op)
                        OP_PIN: begin
                            state_d = S_DONE;
                            if (PIN_AVAIL[host_req.pin_selector]) begin
                                res_d.status = {31'h0, pin_s2_q[host_req.pin_selector]};
                                res_d.data   = {31'h0, pin_s2_q[host_req.pin_selector]};
                            end
                        end
                        OP_GETU32: begin
                            state_d = S_DONE;
                            res_d   = '{status: 32'h0,
                                        data: get_word(cap_q, host_req.start_bit_offset)};
                        end
                        OP_IDCODE: begin
                            state_d = S_ACC;
                        end
                        default: begin
                            if (!target_ok) begin
                                state_d = S_DONE;
                                if (host_req.op == OP_WRITE) begin
                                    res_d.status = STAT_UNSUP;
                                end
                            end else if (jtag_mode) begin
                                state_d = S_IR;
                            end else begin
                                state_d = S_ACC;
                            end
                        end
                    endcase
                end
            end
            S_IR, S_ACC, S_POST: begin
                if (!pend_q) begin
                    pend_d    = 1'b1;
                    req_tgl_d = ~req_tgl_q;
                    word_d    = build_word(state_q, cmd_q, jtag_q, cfg_q);
                end else if (ack_evt) begin
                    pend_d = 1'b0;
                    if (rsp_word.ack == ACK_WAIT) begin
                        if (retry_q == 8'(MAX_WAIT)) begin
                            state_d = S_DONE;
                        end else begin
                            retry_d = retry_q + 8'h01;
                        end
                    end else if (rsp_word.ack == ACK_OK) begin
                        cap_d = {cap_q[CAP_BITS-33:0], rsp_word.rdata};
                        if (state_q == S_IR) begin
                            state_d   = S_ACC;
                            ir_done_d = 1'b1;
                        end else if (state_q == S_ACC && cmd_q.op == OP_READ
                                     && (jtag_q || cmd_q.port_selector)) begin
                            state_d = S_POST;
                        end else begin
                            state_d      = S_DONE;
                            res_d.status = {24'h0, retry_q};
                            res_d.data   = (cmd_q.op == OP_WRITE) ? 32'h0 : rsp_word.rdata;
                        end
                    end else begin
                        state_d = S_DONE;
                    end
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= S_IDLE;
            cmd_q     <= '0;
            cfg_q     <= '0;
            jtag_q    <= 1'b0;
            retry_q   <= 8'h00;
            pend_q    <= 1'b0;
            req_tgl_q <= 1'b0;
            word_q    <= '0;
            res_q     <= '0;
            cap_q     <= '0;
            ir_done_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            cmd_q     <= cmd_d;
            cfg_q     <= cfg_d;
            jtag_q    <= jtag_d;
            retry_q   <= retry_d;
            pend_q    <= pend_d;
            req_tgl_q <= req_tgl_d;
            word_q    <= word_d;
            res_q     <= res_d;
            cap_q     <= cap_d;
            ir_done_q <= ir_done_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host answer and ready
    always_comb begin
        ready_d  = (state_d == S_IDLE);
        rvalid_d = (state_q == S_DONE);
        resp_d   = (state_q == S_DONE) ? res_q : resp_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_q  <= READY_RST;
            rvalid_q <= 1'b0;
            resp_q   <= '0;
        end else begin
            ready_q  <= ready_d;
            rvalid_q <= rvalid_d;
            resp_q   <= resp_d;
        end
    end

    // Millisecond uptime counter
    always_comb begin
        ms_cnt_d = ms_cnt_q + 32'h1;
        up_d     = up_q;
        if (ms_cnt_q == 32'(MS_CYC - 1)) begin
            ms_cnt_d = 32'h0;
            up_d     = up_q + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_cnt_q <= 32'h0;
            up_q     <= 32'h0;
        end else begin
            ms_cnt_q <= ms_cnt_d;
            up_q     <= up_d;
        end
    end

    assign host_ready = ready_q;
    assign resp_valid = rvalid_q;
    assign resp       = resp_q;
    assign uptime_ms  = up_q;

    ////////////////////////////////////////////////////////////////////////////
    // Link side of the handshake
    link_handoff u_link (
        .link_clk       (link_clk),
        .rst_n          (rst_n),
        .req_tgl        (req_tgl_q),
        .req_word       (word_q),
        .ack_tgl        (ack_tgl),
        .rsp_word       (rsp_word),
        .link_req_valid (link_req_valid),
        .link_req       (link_req),
        .link_rsp_valid (link_rsp_valid),
        .link_rsp       (link_rsp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_accept(op_t o);
        state_q == S_IDLE && host_req_valid && ready_q && host_req.op == o;
    endsequence
    sequence s_link_ack(ack_t a);
        state_q != S_IDLE && state_q != S_DONE && pend_q && ack_evt && rsp_word.ack == a;
    endsequence
    sequence s_reissue;
        !pend_q && state_q == $past(state_q) ##1 pend_q && req_tgl_q != $past(req_tgl_q);
    endsequence

    property p_post_read;
        s_link_ack(ACK_OK) and (state_q == S_ACC && cmd_q.op == OP_READ && cmd_q.port_selector)
            |=> state_q == S_POST ##1 word_q.kind == LK_POST && word_q.register_index == RDBUFF_IDX;
    endproperty
    a_post_read: assert property (p_post_read) else $error("posted read not collected");

    property p_ir_ap;
        state_q == S_IR && !pend_q && cmd_q.port_selector
            |=> word_q.kind == LK_IR && word_q.wdata[3:0] == IR_AP_SEL;
    endproperty
    a_ir_ap: assert property (p_ir_ap) else $error("wrong AP select instruction");

    property p_ir_dp;
        state_q == S_IR && !pend_q && !cmd_q.port_selector
            |=> word_q.kind == LK_IR && word_q.wdata[3:0] == IR_DP_SEL;
    endproperty
    a_ir_dp: assert property (p_ir_dp) else $error("wrong DP select instruction");

    property p_acc_after_ir;
        state_q == S_ACC && !pend_q && jtag_q && cmd_q.op != OP_IDCODE |-> ir_done_q;
    endproperty
    a_acc_after_ir: assert property (p_acc_after_ir) else $error("access without IR load");

    property p_wait_retry;
        s_link_ack(ACK_WAIT) and (retry_q != 8'(MAX_WAIT)) |=> s_reissue;
    endproperty
    a_wait_retry: assert property (p_wait_retry) else $error("WAIT not reissued");

    property p_wait_limit;
        s_link_ack(ACK_WAIT) and (retry_q == 8'(MAX_WAIT))
            |-> ##2 resp_valid && resp.status == STAT_ERR;
    endproperty
    a_wait_limit: assert property (p_wait_limit) else $error("WAIT limit not reported");

    property p_fault;
        s_link_ack(ACK_FAULT) |=> state_q == S_DONE ##1 resp_valid && resp.status == STAT_ERR;
    endproperty
    a_fault: assert property (p_fault) else $error("FAULT not ended as error");

    property p_unsup;
        s_accept(OP_WRITE) and !target_ok |-> ##2 resp_valid && resp.status == STAT_UNSUP;
    endproperty
    a_unsup: assert property (p_unsup) else $error("unsupported write status");

    property p_pin;
        s_accept(OP_PIN) |-> ##2 resp_valid
            && (resp.status == 32'h0 || resp.status == 32'h1 || resp.status == STAT_ERR);
    endproperty
    a_pin: assert property (p_pin) else $error("bad pin answer");

    property p_getu32;
        s_accept(OP_GETU32)
            |-> ##2 resp_valid && resp.data == 32'(cap_q >> $past(host_req.start_bit_offset, 2));
    endproperty
    a_getu32: assert property (p_getu32) else $error("wrong extracted word");

    property p_uptime;
        ms_cnt_q == 32'(MS_CYC - 1) |=> uptime_ms == $past(uptime_ms) + 32'h1;
    endproperty
    a_uptime: assert property (p_uptime) else $error("uptime did not advance");

endmodule // dap_access_seq
`default_nettype wire

// file: dap_seq_pkg.sv
// Shared types and constants for the debug port access sequencer
package dap_seq_pkg;

    // Host operations
    typedef enum logic [2:0] {
        OP_READ    = 3'h0,
        OP_WRITE   = 3'h1,
        OP_IDCODE  = 3'h2,
        OP_GETU32  = 3'h3,
        OP_PIN     = 3'h4
    } op_t;

    // Kinds of link transaction
    typedef enum logic [1:0] {
        LK_IR      = 2'h0,
        LK_ACCESS  = 2'h1,
        LK_POST    = 2'h2,
        LK_IDSCAN  = 2'h3
    } link_kind_t;

    // Target acknowledge codes
    typedef enum logic [2:0] {
        ACK_OK     = 3'h1,
        ACK_WAIT   = 3'h2,
        ACK_FAULT  = 3'h4
    } ack_t;

    // Sequencer states, Gray along the access path
    typedef enum logic [2:0] {
        S_IDLE     = 3'h0,
        S_IR       = 3'h1,
        S_ACC      = 3'h3,
        S_POST     = 3'h2,
        S_DONE     = 3'h6
    } state_t;

    // Chain placement of the selected device
    typedef struct packed {
        logic [7:0] ir_bits_toward_output;
        logic [3:0] devices_toward_output;
        logic [7:0] ir_bits_toward_input;
        logic [3:0] devices_toward_input;
        logic [3:0] ir_len;
    } chain_cfg_t;

    // Host request
    typedef struct packed {
        op_t         op;
        logic        port_selector;
        logic [1:0]  register_index;
        logic [31:0] wdata;
        logic [3:0]  chain_position;
        logic [7:0]  start_bit_offset;
        logic [2:0]  pin_selector;
    } host_req_t;

    // Host answer
    typedef struct packed {
        logic [31:0] status;
        logic [31:0] data;
    } resp_t;

    // Word sent to the link
    typedef struct packed {
        link_kind_t  kind;
        logic        port_selector;
        logic        rnw;
        logic [1:0]  register_index;
        logic [31:0] wdata;
        logic [3:0]  chain_position;
        chain_cfg_t  cfg;
    } link_req_t;

    // Word returned by the link
    typedef struct packed {
        ack_t        ack;
        logic [31:0] rdata;
    } link_rsp_t;

    // Status and data codes
    localparam logic [31:0] STAT_ERR    = 32'hFFFFFFFF;
    localparam logic [31:0] STAT_UNSUP  = 32'hFFFFFFFE;
    localparam logic [31:0] ERR_DATA    = 32'hFFFFFFFF;

    // Target port registers and instructions
    localparam logic [1:0]  CTRLSTAT_IDX = 2'h1;
    localparam logic [1:0]  RDBUFF_IDX   = 2'h3;
    localparam int          ORUN_BIT     = 0;
    localparam logic [3:0]  IR_DP_SEL    = 4'hA;
    localparam logic [3:0]  IR_AP_SEL    = 4'hB;

    // Retry limit and capture size
    localparam int          WAIT_LIMIT   = 64;
    localparam int          CAP_BITS     = 256;

    // Millisecond tick derived from the clock period
    localparam int          CLK_NS       = 10;
    localparam int          MS_NS        = 1000000;
    localparam int          MS_CYCLES    = MS_NS / CLK_NS;

    // Reset values
    localparam logic        READY_RST    = 1'b1;

endpackage

// file: link_handoff.sv
// Link clock side of the request and answer handshake
`timescale 1ns/1ns
`default_nettype none
module link_handoff (
    // Link clock and reset
    input  wire logic                    link_clk,
    input  wire logic                    rst_n,
    // To and from the sequencer domain
    input  wire logic                    req_tgl,
    input  wire dap_seq_pkg::link_req_t  req_word,
    output logic                         ack_tgl,
    output var dap_seq_pkg::link_rsp_t   rsp_word,
    // Link to the target
    output logic                         link_req_valid,
    output var dap_seq_pkg::link_req_t   link_req,
    input  wire logic                    link_rsp_valid,
    input  wire dap_seq_pkg::link_rsp_t  link_rsp
);
    import dap_seq_pkg::*;

    logic      tgl_s1_q, tgl_s2_q, tgl_s3_q;
    logic      valid_q, valid_d;
    link_req_t lreq_q, lreq_d;
    link_rsp_t rsp_q, rsp_d;
    logic      ack_q, ack_d;

    ////////////////////////////////////////////////////////////////////////////
    // Next values: new request on toggle, answer closes it
    always_comb begin
        valid_d = valid_q;
        lreq_d  = lreq_q;
        rsp_d   = rsp_q;
        ack_d   = ack_q;
        if (tgl_s2_q != tgl_s3_q) begin
            valid_d = 1'b1;
            lreq_d  = req_word;   // Stable while the toggle is pending
        end else if (valid_q && link_rsp_valid) begin
            valid_d = 1'b0;
            rsp_d   = link_rsp;
            ack_d   = ~ack_q;
        end
    end

    // Registers on the link clock
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
            valid_q  <= 1'b0;
            lreq_q   <= '0;
            rsp_q    <= '0;
            ack_q    <= 1'b0;
        end else begin
            tgl_s1_q <= req_tgl;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
            valid_q  <= valid_d;
            lreq_q   <= lreq_d;
            rsp_q    <= rsp_d;
            ack_q    <= ack_d;
        end
    end

    assign link_req_valid = valid_q;
    assign link_req       = lreq_q;
    assign rsp_word       = rsp_q;
    assign ack_tgl        = ack_q;

endmodule // link_handoff
`default_nettype wire

// file: target_model.sv
// Behavioural target answering link words with WAIT, OK or FAULT
`timescale 1ns/1ns
`default_nettype none
module target_model (
    // Link side
    input  wire logic                   link_clk,
    input  wire logic                   link_req_valid,
    input  wire dap_seq_pkg::link_req_t link_req,
    output logic                        link_rsp_valid,
    output var dap_seq_pkg::link_rsp_t  link_rsp
);
    import dap_seq_pkg::*;
    localparam logic [31:0] POST_VAL = 32'h5A3C96E1;
    localparam logic [31:0] ID_VAL   = 32'h13579BDF; // Arbitrary code of device 0
    // waits_n and fin_ack set by the bench between requests; the rest recorded for the bench to read
    int          waits_n = 0;
    ack_t        fin_ack = ACK_OK;
    int          n_req   = 0;
    logic [3:0]  ir_q    = 4'h0;
    logic [31:0] wd_q    = 32'h0;
    chain_cfg_t  cfg_q   = '0;
    initial link_rsp_valid = 1'b0;
    initial link_rsp = '0;
    // One answer pulse per request; idle answer lines keep changing
    always @(posedge link_clk) begin
        if (link_req_valid && !link_rsp_valid) begin
            n_req <= n_req + 1;
            link_rsp_valid <= 1'b1;
            link_rsp.ack <= (waits_n > 0) ? ACK_WAIT : fin_ack;
            waits_n <= (waits_n > 0) ? waits_n - 1 : 0;
            if (link_req.kind == LK_POST) link_rsp.rdata <= POST_VAL;
            else if (link_req.kind != LK_IDSCAN) link_rsp.rdata <= ~POST_VAL;
            else link_rsp.rdata <= (link_req.chain_position == 4'h0) ? ID_VAL : 32'h0;
            if (link_req.kind == LK_IR) ir_q <= link_req.wdata[3:0];
            if (link_req.kind == LK_ACCESS) wd_q <= link_req.wdata;
            cfg_q <= link_req.cfg;
        end else begin
            link_rsp_valid <= 1'b0;
            link_rsp <= link_rsp_t'(~link_rsp);
        end
    end
endmodule // target_model
`default_nettype wire

// file: debug_port_access_sequencer_bench.sv
// Self-checking bench for the debug port access sequencer
`timescale 1ns/1ns
`default_nettype none
module debug_port_access_sequencer_bench;
    import dap_seq_pkg::*;
    logic        clk = 0, link_clk = 0, rst_n = 0, jtag_mode = 0, target_ok = 1;
    logic        host_req_valid = 0, host_ready, resp_valid, link_req_valid, link_rsp_valid;
    logic [7:0]  probe_pins = 8'h00;
    logic [31:0] uptime_ms;
    host_req_t   host_req = '0;
    resp_t       resp;
    link_req_t   link_req;
    link_rsp_t   link_rsp;
    chain_cfg_t  cfg = '{8'h06, 4'h1, 8'h02, 4'h1, 4'h4};
    int          fail_count = 0, n_compared = 0, cyc = 0, c0;
    dap_access_seq #(.MAX_WAIT(3), .MS_CYC(20)) dut (.clk(clk), .rst_n(rst_n),
        .link_clk(link_clk), .jtag_mode(jtag_mode), .target_ok(target_ok), .chain_cfg(cfg),
        .host_req_valid(host_req_valid), .host_req(host_req), .host_ready(host_ready),
        .resp_valid(resp_valid), .resp(resp), .uptime_ms(uptime_ms), .probe_pins(probe_pins),
        .link_req_valid(link_req_valid), .link_req(link_req), .link_rsp_valid(link_rsp_valid),
        .link_rsp(link_rsp));
    target_model tm (.link_clk(link_clk), .link_req_valid(link_req_valid),
        .link_req(link_req), .link_rsp_valid(link_rsp_valid), .link_rsp(link_rsp));
    // Clocks, link clock offset in phase
    initial forever #5 clk = ~clk;
    initial begin
        #37;
        forever #80 link_clk = ~link_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // One request, then wait for its answer
    task automatic access(input op_t op, input logic ap, input logic jt, input logic ok,
                          input logic [2:0] pin);
        @(posedge clk);
        host_req_valid <= 1'b1;
        host_req <= '{op, ap, 2'h1, 32'hC0DE0F0F, {1'b0, pin}, {pin, 5'h00}, pin};
        jtag_mode <= jt;
        target_ok <= ok;
        @(posedge clk);
        host_req_valid <= 1'b0;
        for (int i = 0; i < 3000 && resp_valid !== 1'b1; i++) @(posedge clk) #1;
        check(resp_valid, 32'h1);
    endtask
    // Write accepted after two WAITs, then too many WAITs
    task automatic t_write_retry();
        tm.waits_n = 2;
        access(OP_WRITE, 1'b0, 1'b0, 1'b1, 3'h0);
        check(resp.status, 32'h2);
        check(resp.data, 32'h0);
        check(tm.wd_q, 32'hC0DE0F0E);
        tm.waits_n = 4;
        access(OP_WRITE, 1'b0, 1'b0, 1'b1, 3'h0);
        check(resp.status, STAT_ERR);
        tm.waits_n = 0;
    endtask
    // FAULT stops at once; unsupported write has its own code
    task automatic t_fault_unsup();
        tm.fin_ack = ACK_FAULT;
        c0 = tm.n_req;
        access(OP_READ, 1'b1, 1'b0, 1'b1, 3'h0);
        check(resp.status, STAT_ERR);
        check(resp.data, ERR_DATA);
        check(tm.n_req - c0, 1);
        tm.fin_ack = ACK_OK;
        access(OP_WRITE, 1'b0, 1'b0, 1'b0, 3'h0);
        check(resp.status, STAT_UNSUP);
    endtask
    // JTAG reads pick the chain and return the posted value
    task automatic t_jtag_read();
        for (int ap = 0; ap < 2; ap++) begin
            c0 = tm.n_req;
            access(OP_READ, ap[0], 1'b1, 1'b1, 3'h0);
            check(tm.ir_q, ap ? IR_AP_SEL : IR_DP_SEL);
            check(tm.n_req - c0, 3);
            check(resp.data, tm.POST_VAL);
            check(resp.status, 32'h0);
            check(tm.cfg_q, cfg);
        end
    endtask
    // Identification codes by chain position
    task automatic t_idcode();
        access(OP_IDCODE, 1'b0, 1'b1, 1'b1, 3'h0);
        check(resp.data, tm.ID_VAL);
        access(OP_IDCODE, 1'b0, 1'b1, 1'b1, 3'h1);
        check(resp.data, 32'h0);
    endtask
    // Pin levels, captured word and uptime
    task automatic t_misc();
        logic [31:0] u0;
        @(posedge clk) probe_pins <= 8'h24;
        for (int p = 0; p < 8; p++) begin
            access(OP_PIN, 1'b0, 1'b0, 1'b1, p[2:0]);
            check(resp.data, {31'h0, p == 2 || p == 5});
        end
        access(OP_GETU32, 1'b0, 1'b0, 1'b1, 3'h0);
        check(resp.data, tm.POST_VAL);
        access(OP_GETU32, 1'b0, 1'b0, 1'b1, 3'h1);
        check(resp.data, ~tm.POST_VAL);
        u0 = uptime_ms;
        repeat (40) @(posedge clk);
        #1;
        check(uptime_ms - u0, 32'h2);
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge link_clk);
        @(posedge clk) rst_n <= 1'b1;
        t_write_retry();
        t_fault_unsup();
        t_jtag_read();
        t_misc();
        t_idcode();
        stop_test();
    end
    // Cycle ceiling against hangs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            stop_test();
        end
    end
endmodule // debug_port_access_sequencer_bench
`default_nettype wire
